// >>> cls_loader.v
`timescale 1ns/1ps
`include "cls_consts.vh"
// Operation
// R1: Oscillator speed follows the image header
// R2: Start application within per-mode deadline
// R3: Restart needs at least 200 ns low
// R4: User pins on within 49 clocks
// R5: Peripheral counts host clock, else oscillator
// R6: Host waits 300 us while memory clears
// R7: Data bits captured on host clock rise
// R8: Host clock between 1 and 25 MHz
// R9: Clock limits apply after sync pattern
// R10: Oscillator off after configuration finishes
// R11: Done low while loading, high after
module cls_loader #(
    parameter CLEAR_CYC = `CLS_CLEAR_CYC,
    parameter MS_CYC    = `CLS_MS_CYC
) (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire [1:0] load_source,
    input  wire       config_restart_n,
    input  wire       host_sck,
    input  wire       host_si,
    input  wire       flash_so,
    output reg        flash_sck,
    output reg        flash_cs_n,
    output reg        config_finished,
    output reg        user_io_pins,
    output reg        load_error,
    output reg  [1:0] osc_mode,
    output reg        img_valid,
    output reg  [7:0] img_byte
);
    // States
    localparam ST_CLEAR = 3'h0;
    localparam ST_SYNC  = 3'h1;
    localparam ST_HDR   = 3'h2;
    localparam ST_LEN   = 3'h3;
    localparam ST_DATA  = 3'h4;
    localparam ST_DONE  = 3'h5;
    localparam ST_FAIL  = 3'h6;

    // Three-stage samplers for pins from other domains
    reg [2:0] rst_sync;     // Restart pin
    reg [2:0] sck_sync;     // Host serial clock
    reg [2:0] si_sync;      // Host serial data
    reg [2:0] so_sync;      // Flash serial data
    reg       rst_lvl_reg;  // Accepted restart level
    reg       sck_lvl_reg;  // Accepted host clock level
    reg       si_lvl_reg;   // Accepted data level
    reg       so_lvl_reg;   // Accepted flash data level
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rst_sync    <= 3'h7;
            sck_sync    <= 3'h0;
            si_sync     <= 3'h0;
            so_sync     <= 3'h0;
            rst_lvl_reg <= 1'b1;
            sck_lvl_reg <= 1'b0;
            si_lvl_reg  <= 1'b0;
            so_lvl_reg  <= 1'b0;
        end else begin
            rst_sync <= {rst_sync[1:0], config_restart_n};
            sck_sync <= {sck_sync[1:0], host_sck};
            si_sync  <= {si_sync[1:0], host_si};
            so_sync  <= {so_sync[1:0], flash_so};
            // Stage 1 is read only by stage 2; levels move when 2 and 3 agree
            if (rst_sync[2] == rst_sync[1])
                rst_lvl_reg <= rst_sync[2];
            if (sck_sync[2] == sck_sync[1])
                sck_lvl_reg <= sck_sync[2];
            if (si_sync[2] == si_sync[1])
                si_lvl_reg <= si_sync[2];
            if (so_sync[2] == so_sync[1])
                so_lvl_reg <= so_sync[2];
        end
    end
    wire sck_rise = (sck_sync[2] == sck_sync[1]) && sck_sync[2] && !sck_lvl_reg;

    reg [7:0] low_cnt_reg;  // Restart low width
    reg       restart_reg;  // Qualified restart pulse
    // Only a low pulse of the least width restarts; glitches are ignored
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            low_cnt_reg <= 8'h00;
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= 1'b0;
            if (!rst_lvl_reg) begin
                if (low_cnt_reg != 8'hff)
                    low_cnt_reg <= low_cnt_reg + 8'h01;
            end else begin
                if (low_cnt_reg >= `CLS_RESTART_CYC)  // see R3
                    restart_reg <= 1'b1;
                low_cnt_reg <= 8'h00;
            end
        end
    end

    // Internal oscillator: a divider whose rate the header picks
    reg [5:0] osc_cnt_reg;  // Divider count
    reg       osc_reg;      // Oscillator level
    reg       osc_tick;     // One pulse per oscillator rise
    reg [5:0] osc_half;     // Half period for the current mode
    always @* begin
        case (osc_mode)
            `CLS_OSC_LOW:  osc_half = `CLS_DIV_LOW;
            `CLS_OSC_HIGH: osc_half = `CLS_DIV_HIGH;
            default:       osc_half = `CLS_DIV_DEFAULT;
        endcase
    end
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            osc_cnt_reg <= 6'h00;
            osc_reg     <= 1'b0;
            osc_tick    <= 1'b0;
        end else begin
            osc_tick <= 1'b0;
            if (osc_mode == `CLS_OSC_OFF) begin  // see R10
                osc_cnt_reg <= 6'h00;
                osc_reg     <= 1'b0;
            end else if (osc_cnt_reg >= osc_half - 6'h01) begin
                osc_cnt_reg <= 6'h00;
                osc_reg     <= !osc_reg;
                osc_tick    <= !osc_reg;
            end else begin
                osc_cnt_reg <= osc_cnt_reg + 6'h01;
            end
        end
    end

    // Bit clock: host clock rise in peripheral mode, else oscillator
    wire periph  = (load_source == `CLS_SRC_PERIPH);
    wire bit_clk = periph ? sck_rise : osc_tick;  // see R5
    wire bit_in  = periph ? si_lvl_reg : so_lvl_reg;

    // Shift register and FIFO feed
    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [15:0] shift_reg;   // Last sixteen bits
    reg  [2:0]  bit_cnt_reg; // Bits of current byte
    reg         byte_rdy;    // Whole byte shifted in
    wire        fifo_in_ready;
    wire [7:0]  fifo_data;
    wire        fifo_valid;
    wire        fifo_pop;
    wire        in_frame = (state_reg != ST_CLEAR) && (state_reg != ST_DONE) && (state_reg != ST_FAIL);
    always @(posedge ref_clk) begin
        if (!rst_n || restart_reg) begin
            shift_reg   <= 16'h0000;
            bit_cnt_reg <= 3'h0;
            byte_rdy    <= 1'b0;
        end else begin
            byte_rdy <= 1'b0;
            // A full FIFO stalls the bit clock; the host must not outrun it
            if (bit_clk && in_frame && fifo_in_ready) begin
                shift_reg <= {shift_reg[14:0], bit_in};  // see R7
                if (state_reg == ST_SYNC) begin
                    bit_cnt_reg <= 3'h0;
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    byte_rdy    <= (bit_cnt_reg == 3'h7);
                end
            end
        end
    end
    wire sync_hit = (state_reg == ST_SYNC) && (shift_reg == `CLS_SYNC_WORD);

    cls_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n && !restart_reg),
        .in_data   (shift_reg[7:0]),
        .in_valid  (byte_rdy),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (1'b1)
    );
    assign fifo_pop = fifo_valid;

    // Sequencer counters
    reg [`CLS_TMR_W-1:0] clr_cnt_reg;   // Memory clear wait
    reg [`CLS_TMR_W-1:0] dl_cnt_reg;    // Elapsed since start
    reg [15:0]           len_reg;       // Bytes still to load
    reg                  len_hi_reg;    // Length high byte taken
    reg [5:0]            io_cnt_reg;    // Post-done clocks
    reg [`CLS_TMR_W-1:0] dl_limit;      // Deadline for mode
    reg [31:0]           dl_full;       // Deadline at full product width
    always @* begin
        case (osc_mode)
            `CLS_OSC_LOW:  dl_full = MS_CYC * `CLS_DL_LOW_MS;
            `CLS_OSC_HIGH: dl_full = MS_CYC * `CLS_DL_HIGH_MS;
            default:       dl_full = MS_CYC * `CLS_DL_DEF_MS;
        endcase
        // Largest deadline fits the timer, so the dropped top bits are zero
        dl_limit = dl_full[`CLS_TMR_W-1:0];
    end

    // Next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_CLEAR: if (clr_cnt_reg >= CLEAR_CYC) state_next = ST_SYNC;  // see R6
            ST_SYNC:  if (sync_hit) state_next = ST_HDR;                   // see R9
            ST_HDR:   if (fifo_pop) state_next = ST_LEN;
            ST_LEN:   if (fifo_pop && len_hi_reg) state_next = ST_DATA;
            ST_DATA:  if (fifo_pop && len_reg == 16'h0001) state_next = ST_DONE;
            ST_DONE:  state_next = ST_DONE;
            ST_FAIL:  state_next = ST_FAIL;
            default:  state_next = ST_CLEAR;
        endcase
        if (!periph && in_frame && state_next != ST_DONE && dl_cnt_reg >= dl_limit)
            state_next = ST_FAIL;  // see R2
    end

    // Sequencer registers and outputs
    always @(posedge ref_clk) begin
        if (!rst_n || restart_reg) begin
            state_reg       <= ST_CLEAR;
            clr_cnt_reg     <= {`CLS_TMR_W{1'b0}};
            dl_cnt_reg      <= {`CLS_TMR_W{1'b0}};
            len_reg         <= 16'h0000;
            len_hi_reg      <= 1'b0;
            io_cnt_reg      <= 6'h00;
            osc_mode        <= `CLS_OSC_DEFAULT;
            config_finished <= 1'b0;
            user_io_pins    <= 1'b0;
            load_error      <= 1'b0;
            flash_cs_n      <= 1'b1;
            flash_sck       <= 1'b0;
            img_valid       <= 1'b0;
            img_byte        <= 8'h00;
        end else begin
            state_reg  <= state_next;
            img_valid  <= 1'b0;
            if (state_reg == ST_CLEAR)
                clr_cnt_reg <= clr_cnt_reg + 1'b1;
            if (in_frame || state_reg == ST_CLEAR)
                dl_cnt_reg <= dl_cnt_reg + 1'b1;
            // Flash selected from the clear wait on, so its first bit settles before the first clock
            flash_cs_n <= !(load_source == `CLS_SRC_MASTER && (in_frame || state_reg == ST_CLEAR));
            flash_sck  <= (load_source == `CLS_SRC_MASTER && in_frame) ? osc_reg : 1'b0;
            if (fifo_pop) begin
                case (state_reg)
                    ST_HDR:  osc_mode <= fifo_data[`CLS_HDR_OSC_LSB +: 2];  // see R1
                    ST_LEN: begin
                        len_reg    <= {len_reg[7:0], fifo_data};
                        len_hi_reg <= 1'b1;
                    end
                    ST_DATA: begin
                        len_reg   <= len_reg - 16'h0001;
                        img_byte  <= fifo_data;
                        img_valid <= 1'b1;
                    end
                    default: len_hi_reg <= len_hi_reg;
                endcase
            end
            if (state_next == ST_FAIL)
                load_error <= 1'b1;
            if (state_next == ST_DONE) begin
                config_finished <= 1'b1;  // see R11
                osc_mode        <= `CLS_OSC_OFF;  // see R10
            end
            // Activation counter after done; host clock keeps it going in peripheral mode
            if (config_finished && !user_io_pins) begin
                if (periph ? sck_rise : 1'b1) begin
                    io_cnt_reg <= io_cnt_reg + 6'h01;
                    if (io_cnt_reg >= `CLS_DONE_IO_CYC - 6'h02)  // see R4
                        user_io_pins <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> cls_consts.vh
`ifndef CLS_CONSTS_VH
`define CLS_CONSTS_VH
// Load source codes
`define CLS_SRC_NVM        2'h0
`define CLS_SRC_MASTER     2'h1
`define CLS_SRC_PERIPH     2'h2
// Oscillator speed codes carried in the image header
`define CLS_OSC_DEFAULT    2'h0
`define CLS_OSC_LOW        2'h1
`define CLS_OSC_HIGH       2'h2
`define CLS_OSC_OFF        2'h3
// Internal oscillator dividers from ref_clk (250 MHz) per mode, half periods
`define CLS_DIV_DEFAULT    6'h19
`define CLS_DIV_LOW        6'h07
`define CLS_DIV_HIGH       6'h05
// Restart pulse least width, ns, and its cycle count at 4 ns
`define CLS_RESTART_NS     200
`define CLS_CLK_NS         4
`define CLS_RESTART_CYC    ((`CLS_RESTART_NS + `CLS_CLK_NS - 1) / `CLS_CLK_NS)
// Memory clear wait, us, and its cycle count
`define CLS_CLEAR_US       300
`define CLS_CLEAR_CYC      (`CLS_CLEAR_US * 1000 / `CLS_CLK_NS)
// Completion deadlines, ms, as cycle counts
`define CLS_DL_DEF_MS      115
`define CLS_DL_LOW_MS      55
`define CLS_DL_HIGH_MS     25
`define CLS_MS_CYC         (1000000 / `CLS_CLK_NS)
// Post-done activation cycles
`define CLS_DONE_IO_CYC    6'h31
// Sync pattern and image header layout
`define CLS_SYNC_WORD      16'h7e99
`define CLS_HDR_OSC_LSB    0
`define CLS_LEN_W          16
// Counter widths
`define CLS_TMR_W          27
`endif

// >>> cls_fifo.v
`timescale 1ns/1ps
// Small word FIFO between the bit shifter and the image writer
module cls_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             ref_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
    reg [AW-1:0]    wr_reg;          // Write pointer
    reg [AW-1:0]    rd_reg;          // Read pointer
    reg [AW:0]      cnt_reg;         // Fill level
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_reg];
    // Pointers and level
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_reg] <= in_data;
                wr_reg      <= wr_reg + 1'b1;
            end
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule

// >>> cls_loader_asserts.sv
`timescale 1ns/1ps
`include "cls_consts.vh"
// Pin-level watch on the loader
module cls_loader_asserts (
    input wire       ref_clk,
    input wire       rst_n,
    input wire [1:0] load_source,
    input wire       config_restart_n,
    input wire       flash_sck,
    input wire       config_finished,
    input wire       user_io_pins,
    input wire [1:0] osc_mode,
    input wire       img_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Image just completed
    sequence s_done_rise;
        $rose(config_finished);
    endsequence
    property p_io_internal;
        s_done_rise ##0 load_source != `CLS_SRC_PERIPH |-> ##[1:49] user_io_pins;
    endproperty
    a_io_internal: assert property (p_io_internal) else $error("user pins late");
    // Host period of 20 cycles puts 49 rises inside 1000 cycles
    property p_io_periph;
        s_done_rise ##0 load_source == `CLS_SRC_PERIPH |-> ##[1:1000] user_io_pins;
    endproperty
    a_io_periph: assert property (p_io_periph) else $error("user pins late, host clock");
    property p_io_late;
        $rose(user_io_pins) |-> $past(config_finished);
    endproperty
    a_io_late: assert property (p_io_late) else $error("user pins before done");
    property p_valid_pulse;
        img_valid |=> !img_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("byte strobe too long");
    property p_osc_off;
        user_io_pins |-> osc_mode == `CLS_OSC_OFF;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator left running");
    property p_sck_quiet;
        user_io_pins |-> !flash_sck;
    endproperty
    a_sck_quiet: assert property (p_sck_quiet) else $error("flash clock after done");
    property p_no_data_after;
        config_finished && $past(config_finished) |-> !img_valid;
    endproperty
    a_no_data_after: assert property (p_no_data_after) else $error("byte after done");
    // Restart acts some cycles after its release, so wait 8 high
    property p_done_holds;
        config_restart_n [*8] ##0 config_finished |=> config_finished;
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done dropped");
endmodule
bind cls_loader cls_loader_asserts i_cls_loader_asserts (
    .ref_clk(ref_clk), .rst_n(rst_n), .load_source(load_source), .config_restart_n(config_restart_n),
    .flash_sck(flash_sck), .config_finished(config_finished), .user_io_pins(user_io_pins),
    .osc_mode(osc_mode), .img_valid(img_valid)
);

// >>> cls_image_src.sv
`timescale 1ns/1ps
// Host processor and serial flash feeding the image
module cls_image_src (
    input  wire        ref_clk,
    input  wire        go,
    input  wire [47:0] image,
    input  wire        flash_sck,
    input  wire        flash_cs_n,
    output logic       host_sck,
    output logic       host_si,
    output logic       flash_so
);
    int fidx = 47; // Next flash bit
    initial begin
        host_sck = 1'b0;
        host_si  = 1'b0;
        flash_so = 1'b0;
    end
    // 80 ns host clock only inside a frame; 49 spare rises after the image
    always begin
        @(posedge ref_clk iff go === 1'b1);
        for (int i = 47; i >= -49; i--) begin
            #1 host_si = (i >= 0) ? image[i] : ~host_si;
            repeat (10) @(posedge ref_clk);
            #1 host_sck = 1'b1;
            repeat (10) @(posedge ref_clk);
            #1 host_sck = 1'b0;
        end
    end
    // Flash: bit ready at select, next on each clock fall; stale bit never held
    always @(negedge flash_cs_n or negedge flash_sck or posedge flash_cs_n) begin
        if (flash_cs_n || fidx < 0) begin
            flash_so = ~flash_so;
            if (flash_cs_n) fidx = 47;
        end else begin
            flash_so = image[fidx];
            fidx--;
        end
    end
endmodule

// >>> cls_loader_test.sv
`timescale 1ns/1ps
`include "cls_consts.vh"
// Self-checking bench for the loader
module cls_loader_test;
    typedef struct packed {
        logic [1:0] src;
        logic [1:0] osc;
        logic [7:0] dat;
        logic [7:0] exp_byte;
        logic [1:0] exp_osc;
    } cls_row_t;
    cls_row_t rows [4] = '{
        '{`CLS_SRC_PERIPH, `CLS_OSC_HIGH, 8'ha5, 8'ha5, `CLS_OSC_HIGH},
        '{`CLS_SRC_MASTER, `CLS_OSC_DEFAULT, 8'h3c, 8'h3c, `CLS_OSC_DEFAULT},
        '{`CLS_SRC_MASTER, `CLS_OSC_LOW, 8'h81, 8'h81, `CLS_OSC_LOW},
        '{`CLS_SRC_MASTER, `CLS_OSC_HIGH, 8'h7e, 8'h7e, `CLS_OSC_HIGH}};
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  load_source = `CLS_SRC_PERIPH;
    logic        config_restart_n = 1'b1;
    logic        go = 1'b0;     // Starts one host frame
    logic [47:0] image = '0;    // Sync, header, length, payload
    logic        seen;
    logic [1:0]  osc_last;      // Mode shown just before done
    wire         host_sck, host_si, flash_so, flash_sck, flash_cs_n;
    wire         config_finished, user_io_pins, load_error, img_valid;
    wire  [1:0]  osc_mode;
    wire  [7:0]  img_byte;
    int          error_cnt = 0;
    int          checks_done = 0;
    cls_loader #(.CLEAR_CYC(20), .MS_CYC(100)) i_cls_loader (
        .ref_clk(ref_clk), .rst_n(rst_n), .load_source(load_source), .config_restart_n(config_restart_n),
        .host_sck(host_sck), .host_si(host_si), .flash_so(flash_so), .flash_sck(flash_sck),
        .flash_cs_n(flash_cs_n), .config_finished(config_finished), .user_io_pins(user_io_pins),
        .load_error(load_error), .osc_mode(osc_mode), .img_valid(img_valid), .img_byte(img_byte));
    cls_image_src i_cls_image_src (
        .ref_clk(ref_clk), .go(go), .image(image), .flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
        .host_sck(host_sck), .host_si(host_si), .flash_so(flash_so));
    always #2 ref_clk = ~ref_clk;
    // Done switches the oscillator off, so keep the mode the header chose
    always @(posedge ref_clk) if (!config_finished) osc_last <= osc_mode;
    task close_out;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait on img_valid, done, user pins or load error
    task wait_sig(input int sel, input int lim);
        int n;
        n = 0;
        while (n < lim && (sel == 0 ? img_valid : sel == 1 ? config_finished :
                           sel == 2 ? user_io_pins : load_error) !== 1'b1) begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (n >= lim) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t wait=%h exp=1", $time, sel);
            close_out();
        end
    endtask
    // 50 cycles low is the 200 ns minimum
    task restart(input logic [1:0] src, input logic [1:0] osc, input logic [7:0] dat);
        image = {`CLS_SYNC_WORD, 6'h00, osc, 16'h0001, dat};
        load_source = src;
        config_restart_n = 1'b0;
        repeat (50) @(posedge ref_clk);
        #1 config_restart_n = 1'b1;
        // Restart takes hold a few cycles after release; old done flag drops then
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task frame;
        go = 1'b1;
        @(posedge ref_clk);
        #1 go = 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        foreach (rows[i]) begin
            restart(rows[i].src, rows[i].osc, rows[i].dat);
            if (rows[i].src == `CLS_SRC_PERIPH) begin
                repeat (30) @(posedge ref_clk);
                #1 frame();
            end
            wait_sig(0, 20000);
            chk(img_byte, rows[i].exp_byte);
            chk({6'h00, osc_last}, {6'h00, rows[i].exp_osc});
            wait_sig(1, 2000);
            chk({7'h00, load_error}, 8'h00);
            wait_sig(2, 1100);
            chk({4'h0, osc_mode, 1'b0, flash_cs_n}, {4'h0, `CLS_OSC_OFF, 2'h1});
        end
        // Bits sent before and inside the clear wait are lost, so the image never frames
        image = {`CLS_SYNC_WORD, 6'h00, `CLS_OSC_LOW, 16'h0001, 8'h42};
        load_source = `CLS_SRC_PERIPH;
        config_restart_n = 1'b0;
        repeat (40) @(posedge ref_clk);
        #1 frame();
        repeat (9) @(posedge ref_clk);
        #1 config_restart_n = 1'b1;
        // Old done flag drops a few cycles after release
        repeat (8) @(posedge ref_clk);
        seen = 1'b0;
        repeat (2100) begin
            @(posedge ref_clk);
            #1 seen = seen | img_valid | config_finished;
        end
        chk({7'h00, seen}, 8'h00);
        // Internal source with no image: load error only once the deadline has run out
        restart(`CLS_SRC_NVM, `CLS_OSC_DEFAULT, 8'h00);
        repeat (11400) @(posedge ref_clk);
        #1 chk({7'h00, load_error}, 8'h00);
        wait_sig(3, 200);
        // Reset in mid-load returns every output to idle
        restart(`CLS_SRC_MASTER, `CLS_OSC_LOW, 8'h99);
        repeat (300) @(posedge ref_clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk({flash_cs_n, config_finished, user_io_pins, img_valid, load_error, osc_mode, flash_sck}, 8'h80);
        close_out();
    end
endmodule
